// File: verilog/vcmd_streamer.sv
/*
 * video command streamer: register port, ring fetch dma, command fifo
 * and header parser dispatching payload to the codec engines.
 * assumes the fetch port returns each requested line as cache-line
 * dwords in order, and that ring tail and length are line multiples.
 */
`include "vcmd_regs.svh"

// Behaviour
// - claim only cycles inside the assigned window
// - ring register write starts the fetch dma
// - fetch address is ring start plus head
// - request whole cache lines, one per step
// - sixteen-line fifo, request only with room
// - private head copy advances per request
// - stop requesting when private head equals tail
// - parser runs while fifo holds data
// - architectural head advances per finished command
// - ring empty when head equals tail
// - header client field steers each command
// - codec commands to engines, others kept inside
// - strip header, forward only payload dwords
// - client 0 memory, 3 codec, others reserved
// - length whole dwords from opcode or field
module vcmd_streamer
   import vcmd_pkg::*;
#(
   parameter int CL_DWORDS  = `VCMD_CL_DWORDS,
   parameter int FIFO_LINES = `VCMD_FIFO_LINES
) (
   // clock and reset
   input  wire logic           ref_clk,
   input  wire logic           rst_n,
   // register programming bus
   input  wire vcmd_reg_req_t  reg_req,
   output logic                reg_ack,
   output logic [31:0]         reg_rdata,
   // memory fetch port
   output logic                mem_req_valid,
   output logic [31:0]         mem_req_addr,
   input  wire logic           mem_req_ready,
   input  wire logic           mem_rsp_valid,
   input  wire logic [31:0]    mem_rsp_data,
   // codec engine front end
   output logic                eng_valid,
   output vcmd_eng_beat_t      eng_beat,
   input  wire logic           eng_ready,
   // status
   output logic                ring_empty,
   output logic                cmd_done,
   output logic                cmd_bad_client
);
   localparam int CW = $clog2(FIFO_LINES) + 1;
   localparam int LW = $clog2(CL_DWORDS);

   // wrapping byte pointer advance
   function automatic logic [31:0] wrap_add(input logic [31:0] p,
                                            input logic [31:0] inc,
                                            input logic [31:0] len);
      logic [31:0] n;
      n = p + inc;
      wrap_add = (n >= len) ? n - len : n;
   endfunction : wrap_add

   logic [31:0] tail_q, start_q, len_q, arch_head_q, dma_head_q;
   logic        en_q;
   logic        hit, wr;
   logic        ack_q;
   logic [31:0] rdata_q;
   logic        req_q;
   logic [31:0] addr_q;
   logic [CW-1:0] credit_q;
   logic [LW-1:0] pop_cnt_q;
   logic        issue, line_freed;
   logic        f_valid, f_ready, f_pop;
   logic [31:0] f_data;
   vcmd_pstate_t st_q;
   logic [8:0]  rem_q, cmd_len_q, hdr_len;
   logic        to_codec_q;
   logic [1:0]  sel_q;
   logic        first_q;
   logic        slot_free, done;
   logic        ev_q;
   vcmd_eng_beat_t beat_q;
   logic        empty_q, done_q, bad_q, bad;
   logic [2:0]  client;
   logic [5:0]  mi_op;

   ////////////////////////////////////////////////////////////////////////
   // register port: window decode, one dword per access
   assign hit = reg_req.valid && (reg_req.addr >= `VCMD_WIN_LO)
                && (reg_req.addr <= `VCMD_WIN_HI);
   assign wr  = hit && reg_req.write;

   // ack and read data for claimed cycles only; unclaimed stay silent
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         ack_q <= hit;
         if (hit && !reg_req.write) begin
            unique case (reg_req.addr)
               `VCMD_RING_TAIL:  rdata_q <= tail_q;
               `VCMD_RING_HEAD:  rdata_q <= arch_head_q;
               `VCMD_RING_START: rdata_q <= start_q;
               `VCMD_RING_CTL:   rdata_q <= len_q | 32'(en_q);
               default:          rdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ring programming; a write to tail or ctl kicks the dma
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tail_q  <= 32'h0000_0000;
         start_q <= 32'h0000_0000;
         len_q   <= 32'h0000_0000;
         en_q    <= 1'b0;
      end else if (wr) begin
         if (reg_req.addr == `VCMD_RING_TAIL) begin
            tail_q <= reg_req.wdata;
         end
         if (reg_req.addr == `VCMD_RING_START) begin
            start_q <= reg_req.wdata;
         end
         if (reg_req.addr == `VCMD_RING_CTL) begin
            len_q <= {reg_req.wdata[31:6], 6'h00};
            en_q  <= reg_req.wdata[`VCMD_CTL_EN_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // fetch dma: one line request per step, only with fifo room reserved
   assign issue = req_q && mem_req_ready;
   assign line_freed = f_pop && (pop_cnt_q == LW'(CL_DWORDS - 1));

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         req_q  <= 1'b0;
         addr_q <= 32'h0000_0000;
      end else if (issue) begin
         req_q <= 1'b0;
      end else if (!req_q && en_q && (dma_head_q != tail_q)
                   && (credit_q != '0)) begin
         req_q  <= 1'b1;
         addr_q <= start_q + dma_head_q;
      end
   end

   // line credits: reserved on issue, returned when a line drains
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         credit_q  <= CW'(FIFO_LINES);
         pop_cnt_q <= '0;
      end else begin
         credit_q <= credit_q - CW'(issue) + CW'(line_freed);
         if (f_pop) begin
            pop_cnt_q <= pop_cnt_q + LW'(1);
         end
      end
   end

   // private head copy; a head write reloads it along with the real one
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dma_head_q <= 32'h0000_0000;
      end else if (wr && reg_req.addr == `VCMD_RING_HEAD) begin
         dma_head_q <= reg_req.wdata;
      end else if (issue) begin
         dma_head_q <= wrap_add(dma_head_q, `VCMD_CL_BYTES, len_q);
      end
   end

   // fill never overflows thanks to credits, so in_ready goes unread
   vcmd_cmd_fifo #(
      .W     (32),
      .DEPTH (FIFO_LINES * CL_DWORDS)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .in_valid  (mem_rsp_valid),
      .in_data   (mem_rsp_data),
      .in_ready  (),
      .out_valid (f_valid),
      .out_data  (f_data),
      .out_ready (f_ready)
   );

   ////////////////////////////////////////////////////////////////////////
   // parser: header decode
   assign client = f_data[31:29];
   assign mi_op  = f_data[28:23];
   always_comb begin
      hdr_len = 9'h001;
      bad     = 1'b0;
      unique case (client)
         `VCMD_CLIENT_MI: begin
            if (mi_op > `VCMD_MI_SINGLE_MAX) begin
               hdr_len = {3'h0, f_data[5:0]} + `VCMD_LEN_BIAS;
            end
         end
         `VCMD_CLIENT_CODEC: begin
            hdr_len = {1'b0, f_data[7:0]} + `VCMD_LEN_BIAS;
         end
         default: begin
            bad = 1'b1;            // reserved: skip the header alone
         end
      endcase
   end

   // codec payload pops wait for a free engine slot; the header and other payload never do
   assign slot_free = !ev_q || eng_ready;
   assign f_ready = (st_q == VCMD_P_HDR) || !to_codec_q || slot_free;
   assign f_pop   = f_valid && f_ready;
   assign done = f_pop && ((st_q == VCMD_P_HDR) ? (hdr_len == 9'h001)
                                               : (rem_q == 9'h001));

   // sequencing through header and payload dwords
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q       <= VCMD_P_HDR;
         rem_q      <= 9'h000;
         cmd_len_q  <= 9'h001;
         to_codec_q <= 1'b0;
         sel_q      <= `VCMD_ENG_AVC;
         first_q    <= 1'b0;
      end else if (f_pop) begin
         unique case (st_q)
            VCMD_P_HDR: begin
               cmd_len_q  <= hdr_len;
               to_codec_q <= (client == `VCMD_CLIENT_CODEC);
               sel_q      <= f_data[17:16];
               first_q    <= 1'b1;
               if (hdr_len != 9'h001) begin
                  rem_q <= hdr_len - 9'h001;
                  st_q  <= VCMD_P_PAY;
               end
            end
            VCMD_P_PAY: begin
               first_q <= 1'b0;
               rem_q   <= rem_q - 9'h001;
               if (rem_q == 9'h001) begin
                  st_q <= VCMD_P_HDR;
               end
            end
         endcase
      end
   end

   // engine output register, held until the engine takes it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ev_q   <= 1'b0;
         beat_q <= '0;
      end else if (slot_free) begin
         ev_q <= f_pop && (st_q == VCMD_P_PAY) && to_codec_q;
         if (f_pop) begin
            beat_q <= '{sel: sel_q, first: first_q,
                        last: (rem_q == 9'h001), data: f_data};
         end
      end
   end

   // architectural head moves on a head write or when a whole command is through
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         arch_head_q <= 32'h0000_0000;
      end else if (wr && reg_req.addr == `VCMD_RING_HEAD) begin
         arch_head_q <= reg_req.wdata;
      end else if (done) begin
         arch_head_q <= wrap_add(arch_head_q,
            {21'h0, ((st_q == VCMD_P_HDR) ? hdr_len : cmd_len_q), 2'b00},
            len_q);
      end
   end

   // status flags; reserved clients are reported, not dispatched
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         empty_q <= 1'b1;
         done_q  <= 1'b0;
         bad_q   <= 1'b0;
      end else begin
         empty_q <= (arch_head_q == tail_q);
         done_q  <= done;
         bad_q   <= f_pop && (st_q == VCMD_P_HDR) && bad;
      end
   end

   assign reg_ack        = ack_q;
   assign reg_rdata      = rdata_q;
   assign mem_req_valid  = req_q;
   assign mem_req_addr   = addr_q;
   assign eng_valid      = ev_q;
   assign eng_beat       = beat_q;
   assign ring_empty     = empty_q;
   assign cmd_done       = done_q;
   assign cmd_bad_client = bad_q;

endmodule : vcmd_streamer

// File: verilog/vcmd_regs.svh
/*
 * register offsets, field positions and sizing constants of the
 * video command streamer.
 * assumes it is included by its bare name from the package and modules.
 */
`ifndef VCMD_REGS_SVH
`define VCMD_REGS_SVH

// claimed window on the register programming bus
`define VCMD_WIN_LO        32'h0000_4000
`define VCMD_WIN_HI        32'h0004_ffff

// primary_ring_zero registers (byte addresses)
`define VCMD_RING_TAIL     32'h0000_4030
`define VCMD_RING_HEAD     32'h0000_4034
`define VCMD_RING_START    32'h0000_4038
`define VCMD_RING_CTL      32'h0000_403c
`define VCMD_CTL_EN_BIT    0

// cache_line_unit and command fifo sizing
`define VCMD_CL_BYTES      32'h0000_0040
`define VCMD_CL_DWORDS     16
`define VCMD_FIFO_LINES    16

// header decode
`define VCMD_CLIENT_MI     3'h0
`define VCMD_CLIENT_CODEC  3'h3
`define VCMD_MI_NOP        6'h00
`define VCMD_MI_SINGLE_MAX 6'h0f
`define VCMD_LEN_BIAS      9'h002
`define VCMD_ENG_AVC       2'h0
`define VCMD_ENG_VC1       2'h1
`define VCMD_ENG_MPEG2     2'h2

`endif

// File: verilog/vcmd_pkg.sv
/*
 * types shared by the video command streamer modules.
 * assumes vcmd_regs.svh is on the include path.
 */
`include "vcmd_regs.svh"

package vcmd_pkg;

   // one access of the register programming bus
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } vcmd_reg_req_t;

   // one payload dword towards a codec engine front end
   typedef struct packed {
      logic [1:0]  sel;
      logic        first;
      logic        last;
      logic [31:0] data;
   } vcmd_eng_beat_t;

   typedef enum logic [0:0] {
      VCMD_P_HDR = 1'b0,
      VCMD_P_PAY = 1'b1
   } vcmd_pstate_t;

endpackage : vcmd_pkg

// File: verilog/vcmd_cmd_fifo.sv
/*
 * flop based command fifo holding fetched ring dwords.
 * assumes one clock; the writer never pushes into a full fifo unless it
 * watches in_ready.
 */
module vcmd_cmd_fifo #(
   parameter int W     = 32,
   parameter int DEPTH = 256
) (
   // clock and reset
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   // fill side
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   // drain side
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0]   cnt_q;
   logic          push;
   logic          pop;

   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   ////////////////////////////////////////////////////////////////////////
   // storage is not reset: only entries below the count are ever read
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   // pointers wrap naturally since depth is a power of two
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + AW'(1);
         end
         if (pop) begin
            rd_q <= rd_q + AW'(1);
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule : vcmd_cmd_fifo

// File: verification/vcmd_streamer_props.sv
/*
 * checker of the video command streamer's port behaviour.
 * assumes it is bound to vcmd_streamer and sees only its ports.
 */
`include "vcmd_regs.svh"

module vcmd_streamer_props
   import vcmd_pkg::*;
(
   // clock and reset
   input wire logic           ref_clk,
   input wire logic           rst_n,
   // register bus
   input wire vcmd_reg_req_t  reg_req,
   input wire logic           reg_ack,
   input wire logic [31:0]    reg_rdata,
   // fetch port
   input wire logic           mem_req_valid,
   input wire logic [31:0]    mem_req_addr,
   input wire logic           mem_req_ready,
   // engine port
   input wire logic           eng_valid,
   input wire vcmd_eng_beat_t eng_beat,
   input wire logic           eng_ready
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   logic in_win;
   logic in_cmd_q;
   assign in_win = reg_req.valid && reg_req.addr >= `VCMD_WIN_LO
                   && reg_req.addr <= `VCMD_WIN_HI;

   // tracks whether a payload run has started at the engine
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) in_cmd_q <= 1'b0;
      else if (eng_valid && eng_ready) in_cmd_q <= !eng_beat.last;
   end

   ////////////////////////////////////////////////////////////////////////
   property p_ack_in; in_win |=> reg_ack; endproperty
   a_ack_in: assert property (p_ack_in) else $error("no ack");
   property p_ack_out; !in_win |=> !reg_ack; endproperty
   a_ack_out: assert property (p_ack_out) else $error("stray ack");
   property p_rdata_hold;
      !$past(in_win && !reg_req.write) |-> $stable(reg_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("rdata moved");
   property p_req_hold;
      mem_req_valid && !mem_req_ready |=>
         mem_req_valid && $stable(mem_req_addr);
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("req dropped");
   property p_req_gap; mem_req_valid && mem_req_ready |=> !mem_req_valid;
   endproperty
   a_req_gap: assert property (p_req_gap) else $error("req no gap");
   property p_line_align; mem_req_valid |-> mem_req_addr[5:0] == 6'h00;
   endproperty
   a_line_align: assert property (p_line_align)
      else $error("unaligned");
   property p_eng_hold;
      eng_valid && !eng_ready |=> eng_valid && $stable(eng_beat);
   endproperty
   a_eng_hold: assert property (p_eng_hold) else $error("beat moved");
   property p_eng_first; eng_valid |-> eng_beat.first == !in_cmd_q;
   endproperty
   a_eng_first: assert property (p_eng_first) else $error("first bad");
   property p_eng_sel; eng_valid |-> eng_beat.sel != 2'h3; endproperty
   a_eng_sel: assert property (p_eng_sel) else $error("bad engine");
endmodule : vcmd_streamer_props

bind vcmd_streamer vcmd_streamer_props u_props (.ref_clk, .rst_n,
   .reg_req, .reg_ack, .reg_rdata, .mem_req_valid, .mem_req_addr,
   .mem_req_ready, .eng_valid, .eng_beat, .eng_ready);

// File: verification/vcmd_mem_model.sv
/*
 * memory behind the fetch port: a 1 KiB ring image returned by lines.
 * assumes the ring start is 1 KiB aligned; the bench fills mem.
 */
module vcmd_mem_model (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // request and response
   input  wire logic        req_valid,
   input  wire logic [31:0] req_addr,
   output logic             req_ready,
   output logic             rsp_valid,
   output logic [31:0]      rsp_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] mem [0:255];
   logic [3:0]  line_q [$];
   logic [3:0]  beat;
   logic [31:0] s;

   // random stalls on both sides; idle data inverts so no stale match
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data  <= 32'h0;
         beat = 4'h0;
         s = 32'h1357;
         line_q.delete();
      end else begin
         s = s ^ (s << 13);
         s = s ^ (s >> 17);
         s = s ^ (s << 5);
         if (req_valid && req_ready) line_q.push_back(req_addr[9:6]);
         req_ready <= s[0];
         if (line_q.size() > 0 && s[1]) begin
            rsp_valid <= 1'b1;
            rsp_data  <= mem[{line_q[0], beat}];
            beat = beat + 4'h1;
            if (beat == 4'h0) void'(line_q.pop_front());
         end else begin
            rsp_valid <= 1'b0;
            rsp_data  <= ~rsp_data;
         end
      end
   end
endmodule : vcmd_mem_model

// File: verification/video_command_streamer_bench.sv
/*
 * self-checking bench: fills a ring with random commands, runs it
 * twice, the second run across the wrap, and checks engine beats, counts and head.
 * assumes the design, package and memory model are compiled first.
 */
module video_command_streamer_bench
   import vcmd_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, rst_n, reg_ack, mem_req_valid, mem_req_ready;
   logic mem_rsp_valid, eng_valid, eng_ready, ring_empty;
   logic cmd_done, cmd_bad_client;
   logic [31:0] reg_rdata, mem_req_addr, mem_rsp_data, st;
   vcmd_reg_req_t reg_req;
   vcmd_eng_beat_t eng_beat;
   logic [35:0] expq [$];
   int n_errors, total_checks, n_done, n_bad, n_lines, e_done, e_bad;

   vcmd_streamer uut (.ref_clk(ref_clk), .rst_n(rst_n),
      .reg_req(reg_req), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
      .mem_req_valid(mem_req_valid), .mem_req_addr(mem_req_addr),
      .mem_req_ready(mem_req_ready), .mem_rsp_valid(mem_rsp_valid),
      .mem_rsp_data(mem_rsp_data), .eng_valid(eng_valid),
      .eng_beat(eng_beat), .eng_ready(eng_ready),
      .ring_empty(ring_empty), .cmd_done(cmd_done),
      .cmd_bad_client(cmd_bad_client));
   vcmd_mem_model u_mem (.ref_clk(ref_clk), .rst_n(rst_n),
      .req_valid(mem_req_valid), .req_addr(mem_req_addr),
      .req_ready(mem_req_ready), .rsp_valid(mem_rsp_valid),
      .rsp_data(mem_rsp_data));

   always #2 ref_clk = ~ref_clk;

   function automatic logic [31:0] rnd();
      st = st ^ (st << 13);
      st = st ^ (st >> 17);
      st = st ^ (st << 5);
      return st;
   endfunction : rnd

   task automatic chk(input logic [35:0] g, input logic [35:0] e);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic tally_and_finish();
      if (n_errors == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish

   // one access held for a single cycle; ack looked at the cycle after
   task automatic reg_op(input logic w, input logic [31:0] a, d,
                         input logic ack, input logic [31:0] rd);
      @(posedge ref_clk);
      reg_req <= '{1'b1, w, a, d};
      @(posedge ref_clk);
      reg_req.valid <= 1'b0;
      #1 chk(reg_ack, ack);
      if (!w && ack) chk(reg_rdata, rd);
   endtask : reg_op

   // random commands filling cnt dwords from dword p; short tails pad
   task automatic fill(input int p, input int cnt);
      int len, j;
      logic [31:0] r, h, d;
      logic [2:0] cl;
      while (cnt > 0) begin
         r = rnd();
         len = (r[2:0] < 3'h4 || r[2:0] == 3'h6) ? r[9:8] + 2 : 1;
         cl = (r[12:10] == 3'h0 || r[12:10] == 3'h3) ? 3'h5 : r[12:10];
         case (r[2:0])
            3'h4: h = 32'h0;
            3'h5: h = 32'h0280_0000;
            3'h6: h = 32'h0800_0000 | r[9:8];
            3'h7: h = {cl, 29'h0};
            default: h = 32'h6000_0000 | (r[4:3] % 3) << 16 | r[9:8];
         endcase
         if (len > cnt) begin
            h = 32'h0;
            len = 1;
         end
         u_mem.mem[p % 256] = h;
         e_done++;
         if (h[31:29] != 3'h0 && h[31:29] != 3'h3) e_bad++;
         for (j = 1; j < len; j++) begin
            d = rnd();
            u_mem.mem[(p + j) % 256] = d;
            if (h[31:29] == 3'h3)
               expq.push_back({h[17:16], j == 1, j == len - 1, d});
         end
         cnt -= len;
         p += len;
      end
   endtask : fill

   // waits for the ring to drain, then compares all results
   task automatic run(input logic [31:0] tail, input int lines);
      int i;
      reg_op(1'b1, `VCMD_RING_TAIL, tail, 1'b1, 32'h0);
      repeat (3) @(posedge ref_clk);
      chk(ring_empty, 1'b0);
      // the last beats may still wait on a stalled engine after empty
      for (i = 0; i < 20000 && (ring_empty !== 1'b1
                                || expq.size() != 0); i++)
         @(posedge ref_clk);
      chk(ring_empty, 1'b1);
      repeat (4) @(posedge ref_clk);
      chk(expq.size(), 0);
      chk(n_done, e_done);
      chk(n_bad, e_bad);
      chk(n_lines, lines);
      reg_op(1'b0, `VCMD_RING_HEAD, 0, 1'b1, tail);
   endtask : run

   ////////////////////////////////////////////////////////////////////////
   // monitors and random engine stalls
   always @(posedge ref_clk) begin
      if (rst_n === 1'b1) begin
         if (eng_valid === 1'b1 && eng_ready === 1'b1) begin
            if (expq.size() == 0) chk(eng_beat, 36'h0);
            else chk(eng_beat, expq.pop_front());
         end
         if (cmd_done === 1'b1) n_done++;
         if (cmd_bad_client === 1'b1) n_bad++;
         if (mem_req_valid === 1'b1 && mem_req_ready === 1'b1) n_lines++;
      end
      eng_ready <= ^rnd();
   end

   initial begin
      #200000;
      n_errors++;
      tally_and_finish();
   end

   initial begin
      ref_clk = 1'b0;
      rst_n = 1'b0;
      st = 32'h4679;
      eng_ready = 1'b0;
      reg_req = '0;
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      reg_op(1'b1, `VCMD_RING_START, 32'h1000, 1'b1, 32'h0);
      reg_op(1'b1, `VCMD_RING_HEAD, 32'h0, 1'b1, 32'h0);
      reg_op(1'b1, `VCMD_RING_CTL, 32'h0401, 1'b1, 32'h0);
      reg_op(1'b1, 32'h3ffc, 32'h40, 1'b0, 32'h0);
      reg_op(1'b1, 32'h5_0030, 32'h40, 1'b0, 32'h0);
      reg_op(1'b0, 32'h5_0034, 32'h0, 1'b0, 32'h0);
      fill(0, 192);
      run(32'h300, 12);
      fill(192, 128);
      run(32'h100, 20);
      tally_and_finish();
   end
endmodule : video_command_streamer_bench
